// *** design/cer_pkg.sv ***
// Purpose: Shared constants and types for completion error reporting.
// Assumes: One 200 MHz clock, tags tracked in a local table.
// Notes: Field positions follow the completion descriptor layout.
// Notes on behaviour
// - A completion with payload flags a payload error as abort in its final beat.
// - Abort is raised when an uncorrectable storage error is seen while fetching data.
// - Every internally caused abort also latches a fatal error.
// - With straddling on, no second packet starts in an aborting beat.
// - Each completion is looked up by tag and its header fields checked.
// - The check result goes to the client as a 4-bit descriptor code.
// - Request done flag sits at descriptor bit 30 on the final completion.
// - Code 0 means clean; code 1 means poisoned, drop data until done.
// - Code 2 reports UR, CA or CRS status, no data, done set.
// - Code 3 reports a byte count short of expected, done set.
// - Code 4 reports requester, class or attribute mismatch on a known tag.
// - Code 5 reports a low address not equal to the next expected byte.
// - Code 6 reports a tag that matches no outstanding request.
// - Code 7 reports a byte count above expected, done set.
// - Each request has a timer; expiry sends a dummy descriptor, code 9.
// - Dummy descriptors hold only code, done, tag and function; other fields zero.
// - A function reset sends code 8 dummies for all of its requests.
// - A tag is freed only after its last completion, timeout or reset.
package cer_pkg;
  localparam int TAG_W = 8;
  localparam int FN_W  = 8;
  localparam int BC_W  = 13;
  localparam int AD_W  = 7;
  localparam int NTAG_DEF = 32;
  localparam int CLK_MHZ = 200;
  localparam int TMO_US  = 50000;
  localparam int TMO_CYC = TMO_US * CLK_MHZ;
  localparam int D_W   = 96;
  localparam int D_ADR = 0;
  localparam int D_ERR = 12;
  localparam int D_BC  = 16;
  localparam int D_DONE = 30;
  localparam int D_FN  = 48;
  localparam int D_TAG = 64;
  localparam logic [2:0] ST_SC = 3'h0;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ABCNT = 8'h08;
  localparam logic [1:0] RSP_OK = 2'h0;
  localparam logic [1:0] RSP_ERR = 2'h2;
  localparam logic CTRL_RST = 1'b0;
  typedef enum logic [3:0] {
    C_OK   = 4'b0000,
    C_POIS = 4'b0001,
    C_STAT = 4'b0010,
    C_BCLO = 4'b0011,
    C_MISM = 4'b0100,
    C_ADDR = 4'b0101,
    C_ITAG = 4'b0110,
    C_BCHI = 4'b0111,
    C_FLR  = 4'b1000,
    C_TMO  = 4'b1001
  } cer_code_t;
  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [15:0]      rid;
    logic [2:0]       tc;
    logic [2:0]       attr;
    logic [2:0]       st;
    logic [BC_W-1:0]  bc;
    logic [AD_W-1:0]  adr;
    logic [BC_W-1:0]  len;
    logic             ep;
  } cer_hdr_t;
endpackage

// *** design/cer_top.sv ***
// Purpose: Checks link completions and reports them to the client as descriptors.
// Assumes: Link header and payload come on the system clock; client never stalls.
// Notes: A header arriving with a last payload beat straddles only if enabled and not aborted, else waits one cycle.
`timescale 1ns/1ps
`default_nettype none
module cer_top
  import cer_pkg::*;
#(
  parameter int NTAG    = NTAG_DEF,
  parameter int TMO_CNT = TMO_CYC
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic [7:0]        S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output var  logic              S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output var  logic              S_AXI_WREADY_OUT,
  output var  logic [1:0]        S_AXI_BRESP_OUT,
  output var  logic              S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  input  wire logic [7:0]        S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output var  logic              S_AXI_ARREADY_OUT,
  output var  logic [31:0]       S_AXI_RDATA_OUT,
  output var  logic [1:0]        S_AXI_RRESP_OUT,
  output var  logic              S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  input  wire logic              REQ_VALID_IN,
  input  wire logic [FN_W-1:0]   REQ_FN_IN,
  input  wire logic [15:0]       REQ_RID_IN,
  input  wire logic [2:0]        REQ_TC_IN,
  input  wire logic [2:0]        REQ_ATTR_IN,
  input  wire logic [BC_W-1:0]   REQ_BYTES_IN,
  input  wire logic [AD_W-1:0]   REQ_ADR_IN,
  output var  logic              REQ_READY_OUT,
  output var  logic              REQ_TAG_VALID_OUT,
  output var  logic [TAG_W-1:0]  REQ_TAG_OUT,
  input  wire logic              FLR_IN,
  input  wire logic [FN_W-1:0]   FLR_FN_IN,
  input  wire logic              LNK_HDR_VALID_IN,
  input  wire logic [TAG_W-1:0]  LNK_HDR_TAG_IN,
  input  wire logic [15:0]       LNK_HDR_RID_IN,
  input  wire logic [2:0]        LNK_HDR_TC_IN,
  input  wire logic [2:0]        LNK_HDR_ATTR_IN,
  input  wire logic [2:0]        LNK_HDR_ST_IN,
  input  wire logic [BC_W-1:0]   LNK_HDR_BC_IN,
  input  wire logic [AD_W-1:0]   LNK_HDR_ADR_IN,
  input  wire logic [BC_W-1:0]   LNK_HDR_LEN_IN,
  input  wire logic              LNK_HDR_EP_IN,
  input  wire logic              LNK_DAT_VALID_IN,
  input  wire logic [31:0]       LNK_DAT_IN,
  input  wire logic              LNK_DAT_LAST_IN,
  input  wire logic              LNK_DAT_UE_IN,
  output var  logic              LNK_READY_OUT,
  output var  logic              CPL_VALID_OUT,
  output var  logic [2*D_W-1:0]  CPL_DATA_OUT,
  output var  logic              CPL_SOF0_OUT,
  output var  logic              CPL_SOF1_OUT,
  output var  logic              CPL_EOF0_OUT,
  output var  logic              CPL_EOF1_OUT,
  output var  logic              CPL_ABORT_OUT,
  output var  logic              FATAL_ERR_OUT
);
  cer_trk_if t ();
  cer_tracker #(.NTAG(NTAG), .TMO(TMO_CNT)) cer_tracker_inst (
    .clk   (SYS_CLK_IN),
    .rst_n (RST_N_IN),
    .t     (t)
  );

  logic       strad_r, fatal_r, hold_r, inpkt_r, ue_r, rdy_r, rq_rdy_r;
  logic [15:0] abcnt_r;
  cer_hdr_t   hold_hdr_r, in_hdr, h;
  logic       in_hv, dv, dl, abort, merge, proc, dmy_go, done, has_dat, okfld;
  cer_code_t  code;
  logic [D_W-1:0] desc, ddesc;

  assign in_hdr = '{tag: LNK_HDR_TAG_IN, rid: LNK_HDR_RID_IN, tc: LNK_HDR_TC_IN,
                    attr: LNK_HDR_ATTR_IN, st: LNK_HDR_ST_IN, bc: LNK_HDR_BC_IN,
                    adr: LNK_HDR_ADR_IN, len: LNK_HDR_LEN_IN, ep: LNK_HDR_EP_IN};
  assign in_hv = rdy_r & LNK_HDR_VALID_IN;
  assign dv = rdy_r & LNK_DAT_VALID_IN;
  assign dl = dv & LNK_DAT_LAST_IN;
  assign abort = dl & (LNK_DAT_UE_IN | ue_r);
  // A new packet may share the ending beat only when that beat is not aborted.
  assign merge = strad_r & ~abort;
  assign proc = hold_r | (in_hv & ~(dl & ~merge));
  assign h = hold_r ? hold_hdr_r : in_hdr;
  assign has_dat = h.len != '0;
  assign dmy_go = ~rdy_r & ~hold_r & ~inpkt_r & t.d_valid;
  assign okfld = h.rid == t.l_rid && h.tc == t.l_tc && h.attr == t.l_attr;

  always_comb begin
    code = C_OK;
    done = 1'b0;
    if (!t.l_hit) begin
      code = C_ITAG;
    end else if (!okfld) begin
      code = C_MISM;
    end else if (h.st != ST_SC) begin
      code = C_STAT;
      done = 1'b1;
    end else if (h.adr != t.l_adr) begin
      code = C_ADDR;
    end else if (h.bc > t.l_rem) begin
      code = C_BCHI;
      done = 1'b1;
    end else if (h.bc < t.l_rem) begin
      code = C_BCLO;
      done = 1'b1;
    end else begin
      code = h.ep ? C_POIS : C_OK;
      done = h.len >= h.bc;
    end
  end

  always_comb begin
    desc = '0;
    desc[D_ADR +: AD_W] = h.adr;
    desc[D_ERR +: 4] = code;
    desc[D_BC +: BC_W] = h.bc;
    desc[D_DONE] = done;
    desc[D_FN +: FN_W] = t.l_hit ? t.l_fn : '0;
    desc[D_TAG +: TAG_W] = h.tag;
    ddesc = '0;
    ddesc[D_ERR +: 4] = t.d_flr ? C_FLR : C_TMO;
    ddesc[D_DONE] = 1'b1;
    ddesc[D_FN +: FN_W] = t.d_fn;
    ddesc[D_TAG +: TAG_W] = t.d_tag;
  end

  assign t.l_tag = h.tag;
  assign t.upd = proc & t.l_hit & (code == C_OK || code == C_POIS);
  assign t.u_rem = t.l_rem - h.len;
  assign t.u_adr = t.l_adr + h.len[AD_W-1:0];
  assign t.rel = proc & t.l_hit & done;
  assign t.flr = FLR_IN;
  assign t.flr_fn = FLR_FN_IN;
  assign t.d_take = dmy_go;
  assign t.alloc = REQ_VALID_IN & rq_rdy_r & t.free_ok;
  assign t.a_fn = REQ_FN_IN;
  assign t.a_rid = REQ_RID_IN;
  assign t.a_tc = REQ_TC_IN;
  assign t.a_attr = REQ_ATTR_IN;
  assign t.a_bytes = REQ_BYTES_IN;
  assign t.a_adr = REQ_ADR_IN;

  // A header meeting an aborted or non-straddled last beat waits one cycle.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      hold_r <= 1'b0;
      hold_hdr_r <= '0;
      inpkt_r <= 1'b0;
      ue_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      hold_r <= in_hv & dl & ~merge;
      if (in_hv) begin
        hold_hdr_r <= in_hdr;
      end
      if (proc && has_dat) begin
        inpkt_r <= 1'b1;
      end else if (dl) begin
        inpkt_r <= 1'b0;
      end
      ue_r <= ~dl & (ue_r | (dv & LNK_DAT_UE_IN));
      rdy_r <= ~(in_hv & dl & ~merge) &
               ~(t.d_valid & ~(proc & has_dat) & (~inpkt_r | dl));
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CPL_VALID_OUT <= 1'b0;
      CPL_DATA_OUT <= '0;
      CPL_SOF0_OUT <= 1'b0;
      CPL_SOF1_OUT <= 1'b0;
      CPL_EOF0_OUT <= 1'b0;
      CPL_EOF1_OUT <= 1'b0;
      CPL_ABORT_OUT <= 1'b0;
    end else begin
      CPL_VALID_OUT <= dv | proc | dmy_go;
      CPL_DATA_OUT <= '0;
      CPL_SOF0_OUT <= proc | dmy_go;
      CPL_SOF1_OUT <= dv & proc;
      CPL_EOF0_OUT <= dl | dmy_go | (proc & ~has_dat & ~dv);
      CPL_EOF1_OUT <= dv & proc & ~has_dat;
      CPL_ABORT_OUT <= abort;
      if (dv) begin
        CPL_DATA_OUT[31:0] <= LNK_DAT_IN;
        if (proc) begin
          CPL_DATA_OUT[D_W +: D_W] <= desc;
        end
      end else if (proc) begin
        CPL_DATA_OUT[D_W-1:0] <= desc;
      end else if (dmy_go) begin
        CPL_DATA_OUT[D_W-1:0] <= ddesc;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rq_rdy_r <= 1'b0;
      REQ_TAG_VALID_OUT <= 1'b0;
      REQ_TAG_OUT <= '0;
    end else begin
      rq_rdy_r <= t.free_ok & ~t.alloc;
      REQ_TAG_VALID_OUT <= t.alloc;
      if (t.alloc) begin
        REQ_TAG_OUT <= t.free_tag;
      end
    end
  end
  assign REQ_READY_OUT = rq_rdy_r;
  assign LNK_READY_OUT = rdy_r;
  assign FATAL_ERR_OUT = fatal_r;

  logic       aw_got_r, w_got_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r;
  logic       wr_go;
  assign wr_go = aw_got_r & w_got_r & ~S_AXI_BVALID_OUT;

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= RSP_OK;
    end else begin
      S_AXI_AWREADY_OUT <= ~aw_got_r & ~(S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT);
      S_AXI_WREADY_OUT <= ~w_got_r & ~(S_AXI_WVALID_IN & S_AXI_WREADY_OUT);
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_got_r <= 1'b1;
        awa_r <= S_AXI_AWADDR_IN;
      end else if (wr_go) begin
        aw_got_r <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_got_r <= 1'b1;
        wd_r <= S_AXI_WSTRB_IN[0] ? S_AXI_WDATA_IN : 32'h0;
      end else if (wr_go) begin
        w_got_r <= 1'b0;
      end
      if (wr_go) begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= (awa_r == A_CTRL || awa_r == A_STAT) ? RSP_OK : RSP_ERR;
      end else if (S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // The fatal flag is set by hardware and cleared by writing one; the set wins.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      strad_r <= CTRL_RST;
      fatal_r <= 1'b0;
      abcnt_r <= '0;
    end else begin
      if (wr_go && awa_r == A_CTRL) begin
        strad_r <= wd_r[0];
      end
      if (abort) begin
        fatal_r <= 1'b1;
        abcnt_r <= abcnt_r + 16'h1;
      end else if (wr_go && awa_r == A_STAT && wd_r[0]) begin
        fatal_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= '0;
      S_AXI_RRESP_OUT <= RSP_OK;
    end else begin
      S_AXI_ARREADY_OUT <= ~S_AXI_RVALID_OUT & ~(S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT);
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RRESP_OUT <= RSP_OK;
        if (S_AXI_ARADDR_IN == A_CTRL) begin
          S_AXI_RDATA_OUT <= {31'h0, strad_r};
        end else if (S_AXI_ARADDR_IN == A_STAT) begin
          S_AXI_RDATA_OUT <= {28'h0, inpkt_r, t.d_valid, ~t.free_ok, fatal_r};
        end else if (S_AXI_ARADDR_IN == A_ABCNT) begin
          S_AXI_RDATA_OUT <= {16'h0, abcnt_r};
        end else begin
          S_AXI_RDATA_OUT <= 32'h0;
          S_AXI_RRESP_OUT <= RSP_ERR;
        end
      end else if (S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** design/cer_tracker.sv ***
// Purpose: Table of outstanding requests with per-entry completion timers.
// Assumes: Release and dummy take never target the same entry in one cycle.
// Notes: Function reset outranks timeout when both are pending on an entry.
`timescale 1ns/1ps
`default_nettype none
module cer_tracker
  import cer_pkg::*;
#(
  parameter int NTAG = NTAG_DEF,
  parameter int TMO  = TMO_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  cer_trk_if.trk   t
);
  localparam int IW = $clog2(NTAG);
  logic [NTAG-1:0] v_r, tp_r, fp_r;
  logic [FN_W-1:0] fn_r [NTAG];
  logic [15:0]     rid_r [NTAG];
  logic [2:0]      tc_r [NTAG];
  logic [2:0]      at_r [NTAG];
  logic [BC_W-1:0] rem_r [NTAG];
  logic [AD_W-1:0] adr_r [NTAG];
  logic [31:0]     cnt_r [NTAG];
  logic [IW-1:0]   fi, di, li;
  logic            dv;

  always_comb begin
    fi = '0;
    di = '0;
    dv = 1'b0;
    for (int i = NTAG - 1; i >= 0; i--) begin
      if (!v_r[i]) begin
        fi = IW'(i);
      end
      if (tp_r[i] || fp_r[i]) begin
        di = IW'(i);
        dv = 1'b1;
      end
    end
  end
  assign li = t.l_tag[IW-1:0];
  assign t.free_ok = ~&v_r;
  assign t.free_tag = TAG_W'(fi);
  assign t.l_hit = (t.l_tag < TAG_W'(NTAG)) && v_r[li];
  assign t.l_fn = fn_r[li];
  assign t.l_rid = rid_r[li];
  assign t.l_tc = tc_r[li];
  assign t.l_attr = at_r[li];
  assign t.l_rem = rem_r[li];
  assign t.l_adr = adr_r[li];
  assign t.d_valid = dv;
  assign t.d_flr = fp_r[di];
  assign t.d_tag = TAG_W'(di);
  assign t.d_fn = fn_r[di];

  // Entries leave the table only on their last completion or a dummy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v_r <= '0;
      tp_r <= '0;
      fp_r <= '0;
    end else begin
      for (int i = 0; i < NTAG; i++) begin
        if (t.alloc && fi == IW'(i)) begin
          v_r[i] <= 1'b1;
        end else if ((t.rel && li == IW'(i)) || (t.d_take && di == IW'(i))) begin
          v_r[i] <= 1'b0;
          tp_r[i] <= 1'b0;
          fp_r[i] <= 1'b0;
        end else begin
          if (v_r[i] && cnt_r[i] == 32'(TMO - 1)) begin
            tp_r[i] <= 1'b1;
          end
          if (v_r[i] && t.flr && fn_r[i] == t.flr_fn) begin
            fp_r[i] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NTAG; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NTAG; i++) begin
        if (t.alloc && fi == IW'(i)) begin
          cnt_r[i] <= '0;
        end else if (v_r[i] && !tp_r[i]) begin
          cnt_r[i] <= cnt_r[i] + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (t.alloc) begin
      fn_r[fi] <= t.a_fn;
      rid_r[fi] <= t.a_rid;
      tc_r[fi] <= t.a_tc;
      at_r[fi] <= t.a_attr;
      rem_r[fi] <= t.a_bytes;
      adr_r[fi] <= t.a_adr;
    end else if (t.upd) begin
      rem_r[li] <= t.u_rem;
      adr_r[li] <= t.u_adr;
    end
  end
endmodule
`default_nettype wire

// *** design/cer_trk_if.sv ***
// Purpose: Carrier between the checker and the request table.
// Assumes: All signals on the system clock.
// Notes: Lookup answers combinationally in the same cycle.
`timescale 1ns/1ps
`default_nettype none
interface cer_trk_if;
  import cer_pkg::*;
  logic             alloc;
  logic             free_ok;
  logic [TAG_W-1:0] free_tag;
  logic [FN_W-1:0]  a_fn;
  logic [15:0]      a_rid;
  logic [2:0]       a_tc;
  logic [2:0]       a_attr;
  logic [BC_W-1:0]  a_bytes;
  logic [AD_W-1:0]  a_adr;
  logic [TAG_W-1:0] l_tag;
  logic             l_hit;
  logic [FN_W-1:0]  l_fn;
  logic [15:0]      l_rid;
  logic [2:0]       l_tc;
  logic [2:0]       l_attr;
  logic [BC_W-1:0]  l_rem;
  logic [AD_W-1:0]  l_adr;
  logic             upd;
  logic [BC_W-1:0]  u_rem;
  logic [AD_W-1:0]  u_adr;
  logic             rel;
  logic             flr;
  logic [FN_W-1:0]  flr_fn;
  logic             d_valid;
  logic             d_take;
  logic             d_flr;
  logic [TAG_W-1:0] d_tag;
  logic [FN_W-1:0]  d_fn;
  modport chk (output alloc, a_fn, a_rid, a_tc, a_attr, a_bytes, a_adr, l_tag, upd, u_rem, u_adr,
               rel, flr, flr_fn, d_take,
               input free_ok, free_tag, l_hit, l_fn, l_rid, l_tc, l_attr, l_rem, l_adr,
               d_valid, d_flr, d_tag, d_fn);
  modport trk (input alloc, a_fn, a_rid, a_tc, a_attr, a_bytes, a_adr, l_tag, upd, u_rem, u_adr,
               rel, flr, flr_fn, d_take,
               output free_ok, free_tag, l_hit, l_fn, l_rid, l_tc, l_attr, l_rem, l_adr,
               d_valid, d_flr, d_tag, d_fn);
endinterface
`default_nettype wire

// *** tb/cer_chk.sv ***
// Purpose: Port-level assertions for completion error reporting.
// Assumes: Lane0 holds the descriptor unless a straddled one is flagged.
// Notes: Bound to the top module from the testbench file.
`timescale 1ns/1ps
`default_nettype none
module cer_chk
  import cer_pkg::*;
(
  input wire logic           SYS_CLK_IN,
  input wire logic           RST_N_IN,
  input wire logic           LNK_READY_OUT,
  input wire logic           LNK_DAT_VALID_IN,
  input wire logic           LNK_DAT_UE_IN,
  input wire logic           CPL_VALID_OUT,
  input wire logic [2*D_W-1:0] CPL_DATA_OUT,
  input wire logic           CPL_SOF0_OUT,
  input wire logic           CPL_SOF1_OUT,
  input wire logic           CPL_EOF0_OUT,
  input wire logic           CPL_EOF1_OUT,
  input wire logic           CPL_ABORT_OUT,
  input wire logic           FATAL_ERR_OUT
);
  // A straddled descriptor sits in lane1, so only lone lane0 descriptors are decoded here.
  wire logic       ds = CPL_VALID_OUT && CPL_SOF0_OUT && !CPL_SOF1_OUT;
  wire logic [3:0] cd = CPL_DATA_OUT[D_ERR+:4];
  wire logic       dn = CPL_DATA_OUT[D_DONE];
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  abort_last_a: assert property (CPL_ABORT_OUT |-> CPL_VALID_OUT && CPL_EOF0_OUT)
    else $error("abort outside a last beat");
  ue_fatal_a: assert property (LNK_DAT_VALID_IN && LNK_DAT_UE_IN && LNK_READY_OUT
    |-> ##[1:4] FATAL_ERR_OUT) else $error("storage error without fatal flag");
  abort_fatal_a: assert property (CPL_ABORT_OUT |-> ##[0:1] FATAL_ERR_OUT)
    else $error("abort without fatal flag");
  abort_single_a: assert property (CPL_ABORT_OUT |-> !CPL_SOF1_OUT && !CPL_EOF1_OUT)
    else $error("second packet in aborting beat");
  straddle_frame_a: assert property (CPL_SOF1_OUT |-> CPL_VALID_OUT && CPL_SOF0_OUT && CPL_EOF0_OUT)
    else $error("straddled start without first end");
  code_range_a: assert property (ds |-> cd <= 4'h9)
    else $error("descriptor code out of range");
  done_codes_a: assert property (ds && cd inside {4'h2, 4'h3, 4'h7, 4'h8, 4'h9}
    |-> dn) else $error("terminating code without done");
  open_codes_a: assert property (ds && cd inside {4'h4, 4'h5, 4'h6} |-> !dn)
    else $error("open code with done set");
  dummy_fields_a: assert property (ds && cd[3] |-> CPL_EOF0_OUT && CPL_DATA_OUT[D_BC+:BC_W] == 13'h0
    && CPL_DATA_OUT[D_ADR+:AD_W] == 7'h0) else $error("dummy descriptor carries fields");
  cover property (CPL_SOF1_OUT);
  cover property (CPL_ABORT_OUT);
  cover property (ds && cd == 4'h9);
  cover property (ds && cd == 4'h8);
endmodule
`default_nettype wire

// *** tb/cer_client.sv ***
// Purpose: Client model on the completion stream side.
// Assumes: The stream cannot be stalled, so the model only listens.
// Notes: Counts packets discarded because their last beat was aborted.
`timescale 1ns/1ps
`default_nettype none
module cer_client (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic valid_in,
  input wire logic eof0_in,
  input wire logic abort_in,
  output var int   drops_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      drops_out <= 0;
    end else if (valid_in && eof0_in && abort_in) begin
      drops_out <= drops_out + 1;
    end
  end
endmodule
`default_nettype wire

// *** tb/cer_top_test.sv ***
// Purpose: Self-checking bench for completion error reporting.
// Assumes: Timeout shortened to 50 cycles so timer expiry fits the run.
// Notes: Descriptors are noted in a queue and compared as they appear.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module cer_top_test;
  import cer_pkg::*;
  logic SYS_CLK_IN = 0, RST_N_IN = 0, S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0;
  logic S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0, REQ_VALID_IN = 0, FLR_IN = 0, LNK_HDR_VALID_IN = 0;
  logic LNK_DAT_VALID_IN = 0, LNK_DAT_LAST_IN = 0, LNK_DAT_UE_IN = 0;
  logic [7:0] S_AXI_AWADDR_IN = 0, S_AXI_ARADDR_IN = 0, REQ_FN_IN = 0, FLR_FN_IN = 0;
  logic [31:0] S_AXI_WDATA_IN = 0, LNK_DAT_IN = 0, S_AXI_RDATA_OUT, rnd;
  logic [3:0] S_AXI_WSTRB_IN = 4'hf;
  logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
  logic REQ_READY_OUT, REQ_TAG_VALID_OUT, LNK_READY_OUT, CPL_VALID_OUT, CPL_SOF0_OUT, CPL_SOF1_OUT;
  logic CPL_EOF0_OUT, CPL_EOF1_OUT, CPL_ABORT_OUT, FATAL_ERR_OUT, dn;
  logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
  logic [TAG_W-1:0] REQ_TAG_OUT, t, t2;
  logic [2*D_W-1:0] CPL_DATA_OUT;
  logic [D_W-1:0] d;
  logic [TAG_W+4:0] e, expq[$];
  cer_hdr_t rq = '0, h = '0, c;
  int seed = 34299, miscompares = 0, num_checks = 0, cyc = 0, drops;
  wire logic [15:0] REQ_RID_IN = rq.rid, LNK_HDR_RID_IN = h.rid;
  wire logic [2:0] REQ_TC_IN = rq.tc, REQ_ATTR_IN = rq.attr, LNK_HDR_TC_IN = h.tc, LNK_HDR_ATTR_IN = h.attr;
  wire logic [2:0] LNK_HDR_ST_IN = h.st;
  wire logic [BC_W-1:0] REQ_BYTES_IN = rq.len, LNK_HDR_BC_IN = h.bc, LNK_HDR_LEN_IN = h.len;
  wire logic [AD_W-1:0] REQ_ADR_IN = rq.adr, LNK_HDR_ADR_IN = h.adr;
  wire logic [TAG_W-1:0] LNK_HDR_TAG_IN = h.tag;
  wire logic LNK_HDR_EP_IN = h.ep;
  cer_top #(.TMO_CNT(50)) cer_top_inst (.*);
  cer_client cer_client_inst (.clk_in(SYS_CLK_IN), .rst_n_in(RST_N_IN), .valid_in(CPL_VALID_OUT),
    .eof0_in(CPL_EOF0_OUT), .abort_in(CPL_ABORT_OUT), .drops_out(drops));
  always #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
  task automatic wrap_up;
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge SYS_CLK_IN) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up;
    end
  end
  always @(posedge SYS_CLK_IN) begin
    if (CPL_VALID_OUT === 1'b1 && CPL_SOF0_OUT === 1'b1) begin
      d = (CPL_SOF1_OUT === 1'b1) ? CPL_DATA_OUT[2*D_W-1:D_W] : CPL_DATA_OUT[D_W-1:0];
      e = expq.size() ? expq.pop_front() : 'x;
      `CHK("descriptor", e, {d[D_TAG+:TAG_W], d[D_DONE], d[D_ERR+:4]})
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bit ad = 0, wd = 0;
    @(posedge SYS_CLK_IN);
    S_AXI_AWADDR_IN <= a; S_AXI_WDATA_IN <= v; S_AXI_AWVALID_IN <= 1; S_AXI_WVALID_IN <= 1;
    S_AXI_BREADY_IN <= 1;
    while (!(ad && wd)) begin
      @(posedge SYS_CLK_IN);
      if (!ad && S_AXI_AWREADY_OUT === 1'b1) begin ad = 1; S_AXI_AWVALID_IN <= 0; end
      if (!wd && S_AXI_WREADY_OUT === 1'b1) begin wd = 1; S_AXI_WVALID_IN <= 0; end
    end
    do @(posedge SYS_CLK_IN); while (S_AXI_BVALID_OUT !== 1'b1);
    `CHK("bresp", r, S_AXI_BRESP_OUT)
    S_AXI_BREADY_IN <= 0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge SYS_CLK_IN);
    S_AXI_ARADDR_IN <= a; S_AXI_ARVALID_IN <= 1; S_AXI_RREADY_IN <= 1;
    do @(posedge SYS_CLK_IN); while (S_AXI_ARREADY_OUT !== 1'b1);
    S_AXI_ARVALID_IN <= 0;
    do @(posedge SYS_CLK_IN); while (S_AXI_RVALID_OUT !== 1'b1);
    `CHK("rdata", v, S_AXI_RDATA_OUT)
    `CHK("rresp", r, S_AXI_RRESP_OUT)
    S_AXI_RREADY_IN <= 0;
  endtask
  task automatic req(output logic [TAG_W-1:0] tg);
    @(posedge SYS_CLK_IN);
    REQ_VALID_IN <= 1;
    do @(posedge SYS_CLK_IN); while (REQ_READY_OUT !== 1'b1);
    REQ_VALID_IN <= 0;
    do @(posedge SYS_CLK_IN); while (REQ_TAG_VALID_OUT !== 1'b1);
    tg = REQ_TAG_OUT;
  endtask
  task automatic lwait;
    do @(posedge SYS_CLK_IN); while (LNK_READY_OUT !== 1'b1);
  endtask
  task automatic snd(input cer_hdr_t x, input logic ue);
    int n = (x.len + 3) / 4;
    @(posedge SYS_CLK_IN);
    h <= x; LNK_HDR_VALID_IN <= 1;
    lwait;
    // Released header lines are scrambled so nothing leans on stale values.
    h <= cer_hdr_t'(~x); LNK_HDR_VALID_IN <= 0;
    for (int b = 0; b < n; b++) begin
      rnd = $random(seed);
      LNK_DAT_VALID_IN <= 1; LNK_DAT_IN <= rnd; LNK_DAT_LAST_IN <= (b == n - 1);
      LNK_DAT_UE_IN <= ue && b == 0;
      lwait;
    end
    LNK_DAT_VALID_IN <= 0; LNK_DAT_LAST_IN <= 0; LNK_DAT_UE_IN <= 0;
  endtask
  task automatic drain;
    while (expq.size() != 0) @(posedge SYS_CLK_IN);
  endtask
  initial begin
    repeat (5) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1;
    repeat (2) @(posedge SYS_CLK_IN);
    axr(A_CTRL, 32'h0, RSP_OK);
    axr(A_STAT, 32'h0, RSP_OK);
    axr(A_ABCNT, 32'h0, RSP_OK);
    axr(8'h0c, 32'h0, RSP_ERR);
    axw(A_ABCNT, 32'h1, RSP_ERR);
    for (int k = 0; k < 9; k++) begin
      rnd = $random(seed);
      c = '0; c.rid = rnd[15:0]; c.tc = rnd[18:16]; c.attr = rnd[21:19]; c.len = 13'h8; c.bc = 13'h8;
      rq <= c; REQ_FN_IN <= rnd[31:24];
      req(t);
      c.tag = t;
      case (k)
        1: c.ep = 1;
        2: begin c.st = 3'h1; c.len = 13'h0; end
        3: begin c.bc = 13'h4; c.len = 13'h4; end
        4: c.rid = ~c.rid;
        5: c.adr = 7'h04;
        6: c.tag = 8'hff;
        7: c.bc = 13'hc;
        default: ;
      endcase
      dn = !(k inside {4, 5, 6});
      expq.push_back({c.tag, dn, (k == 8) ? 4'h0 : 4'(k)});
      if (!dn) expq.push_back({t, 1'b1, 4'h9});
      snd(c, k == 8);
      drain;
    end
    axr(A_STAT, 32'h1, RSP_OK);
    axw(A_STAT, 32'h1, RSP_OK);
    axr(A_STAT, 32'h0, RSP_OK);
    axr(A_ABCNT, 32'h1, RSP_OK);
    REQ_FN_IN <= 8'h5a;
    req(t);
    REQ_FN_IN <= 8'h5b;
    req(t2);
    expq.push_back({t, 1'b1, 4'h8});
    expq.push_back({t2, 1'b1, 4'h9});
    FLR_IN <= 1; FLR_FN_IN <= 8'h5a;
    @(posedge SYS_CLK_IN);
    FLR_IN <= 0;
    drain;
    axw(A_CTRL, 32'h1, RSP_OK);
    axr(A_CTRL, 32'h1, RSP_OK);
    for (int s = 0; s < 2; s++) begin
      c = '0; c.len = 13'h4; c.bc = 13'h4;
      rq <= c;
      req(t);
      req(t2);
      c.tag = t;
      expq.push_back({t, 1'b1, 4'h0});
      expq.push_back({t2, 1'b1, 4'h2});
      h <= c; LNK_HDR_VALID_IN <= 1;
      lwait;
      c.tag = t2; c.st = 3'h1; c.len = 13'h0;
      h <= c; LNK_DAT_VALID_IN <= 1; LNK_DAT_LAST_IN <= 1; LNK_DAT_UE_IN <= (s == 1);
      lwait;
      LNK_HDR_VALID_IN <= 0; LNK_DAT_VALID_IN <= 0; LNK_DAT_LAST_IN <= 0; LNK_DAT_UE_IN <= 0;
      h <= cer_hdr_t'(~c);
      drain;
    end
    axr(A_ABCNT, 32'h2, RSP_OK);
    `CHK("client drops", 2, drops)
    wrap_up;
  end
endmodule
bind cer_top cer_chk cer_chk_inst (.*);
`default_nettype wire
